// >>> bts_dec_if.sv
// Decoded fields of the instruction in the execute stage
`timescale 1ns/1ns
interface bts_dec_if;
  logic [bts_pkg::WORD_W-1:0] word;
  logic skip_if_bit_clear;
  logic skip_if_bit_set;
  logic [bts_pkg::BSEL_W-1:0] bit_sel;
  logic [bts_pkg::ADDR_W-1:0] file_addr;
  modport core (output word, input skip_if_bit_clear, input skip_if_bit_set, input bit_sel, input file_addr);
  modport dec (input word, output skip_if_bit_clear, output skip_if_bit_set, output bit_sel, output file_addr);
endinterface : bts_dec_if

// >>> bts_decode.sv
// Field decoder for the two bit-test-and-skip instructions
`timescale 1ns/1ns
module bts_decode (
  bts_dec_if.dec dec
);
  function automatic logic bts_opc_is(input logic [bts_pkg::WORD_W-1:0] w, input logic [bts_pkg::OPC_W-1:0] opc);
    bts_opc_is = (w[bts_pkg::OPC_MSB:bts_pkg::OPC_LSB] == opc);
  endfunction : bts_opc_is

  always_comb
  begin
    dec.skip_if_bit_clear = bts_opc_is(dec.word, bts_pkg::OPC_SKIP_CLEAR); // [RULE_01]
    dec.skip_if_bit_set = bts_opc_is(dec.word, bts_pkg::OPC_SKIP_SET); // [RULE_02]
    // Three bits cover positions 0..7 only
    dec.bit_sel = dec.word[bts_pkg::BSEL_MSB:bts_pkg::BSEL_LSB]; // [RULE_05]
    dec.file_addr = dec.word[bts_pkg::ADDR_MSB:bts_pkg::ADDR_LSB]; // [RULE_01]
  end
endmodule : bts_decode

// >>> bts_exec.sv
// Execute stage for the bit-test-and-skip instructions
`timescale 1ns/1ns
// What this block does
// [RULE_01] Word 0110 bbbf ffff skips next instruction when file bit b is zero.
// [RULE_02] Word 0111 bbbf ffff skips next instruction when file bit b is one.
// [RULE_03] Taken skip squashes prefetched word, runs a no-op: two cycles, else one.
// [RULE_04] Next instruction is fetched while the bit test executes.
// [RULE_05] No status flag changes; one word each; bit select spans zero to seven.
module bts_exec (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic fetch_valid,
  input wire logic [bts_pkg::WORD_W-1:0] fetch_word,
  output logic [bts_pkg::ADDR_W-1:0] file_addr,
  input wire logic [bts_pkg::DATA_W-1:0] file_rdata,
  output logic exec_valid,
  output logic [bts_pkg::WORD_W-1:0] exec_word,
  output logic exec_nop,
  output logic skip_taken,
  output logic test_busy,
  output logic status_we
);
  logic [bts_pkg::RST_SYNC_STAGES-1:0] rst_sync;
  logic rst_n;
  logic valid;
  logic squash;
  logic [bts_pkg::WORD_W-1:0] word;
  logic next_valid;
  logic next_squash;
  logic [bts_pkg::WORD_W-1:0] next_word;
  logic live;
  logic tested_bit;
  logic skip_now;

  bts_dec_if dec_bus ();

  bts_decode u_decode (
    .dec(dec_bus)
  );

  // Asynchronous assert, synchronous release
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync <= '0;
    else
      rst_sync <= {rst_sync[bts_pkg::RST_SYNC_STAGES-2:0], 1'b1};
  end
  assign rst_n = rst_sync[bts_pkg::RST_SYNC_STAGES-1];

  assign dec_bus.word = word;
  // A squashed slot is a real no-op, so a skip word in it must not skip
  assign live = valid && !squash;
  assign file_addr = dec_bus.file_addr;
  assign tested_bit = file_rdata[dec_bus.bit_sel]; // [RULE_05]
  assign skip_now = live && ((dec_bus.skip_if_bit_clear && !tested_bit) // [RULE_01]
                             || (dec_bus.skip_if_bit_set && tested_bit)); // [RULE_02]

  always_comb
  begin
    next_valid = valid;
    next_word = word;
    next_squash = squash;
    if (fetch_valid)
    begin
      // Prefetched word enters execute right behind the test
      next_valid = 1'b1; // [RULE_04]
      next_word = fetch_word; // [RULE_04]
      // A squash left pending by a stalled fetch lands on this word
      next_squash = skip_now || (squash && !valid); // [RULE_03]
    end
    else if (skip_now)
    begin
      // Fetch stalled: keep the squash pending for the word still to come
      next_valid = 1'b0;
      next_squash = 1'b1; // [RULE_03]
    end
    else if (live || squash)
    begin
      next_valid = 1'b0;
      next_squash = squash && !valid;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid <= bts_pkg::RST_VALID;
      squash <= bts_pkg::RST_SQUASH;
      word <= bts_pkg::NOP_WORD;
    end
    else
    begin
      valid <= next_valid;
      squash <= next_squash;
      word <= next_word;
    end
  end

  assign exec_valid = live;
  assign exec_word = live ? word : bts_pkg::NOP_WORD; // [RULE_03]
  assign exec_nop = valid && squash; // [RULE_03]
  assign skip_taken = skip_now;
  assign test_busy = live && (dec_bus.skip_if_bit_clear || dec_bus.skip_if_bit_set);
  // Bit tests never write status; arithmetic units own that path
  assign status_we = 1'b0; // [RULE_05]
endmodule : bts_exec

// >>> bts_exec_props.sv
// Checker for the bit-test-and-skip execute block
`timescale 1ns/1ns
module bts_exec_props (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic fetch_valid,
  input wire logic [11:0] fetch_word,
  input wire logic [4:0] file_addr,
  input wire logic [7:0] file_rdata,
  input wire logic exec_valid,
  input wire logic [11:0] exec_word,
  input wire logic exec_nop,
  input wire logic skip_taken,
  input wire logic test_busy,
  input wire logic status_we
);
  wire hit = file_rdata[exec_word[7:5]];
  logic [1:0] arm;
  logic pend;
  // Mirrors the block's two-flop reset release; squash waits across fetch stalls
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arm <= 2'h0;
      pend <= 1'h0;
    end
    else
    begin
      arm <= {arm[0], 1'h1};
      pend <= !fetch_valid && (pend || skip_taken);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arm[1]);
  AST_CLEAR: assert property (exec_valid && exec_word[11:8] == 4'h6 |-> skip_taken == !hit)
    else $error("clear test skip wrong");
  AST_SET: assert property (exec_valid && exec_word[11:8] == 4'h7 |-> skip_taken == hit)
    else $error("set test skip wrong");
  AST_SQUASH: assert property (fetch_valid && (pend || skip_taken) |=> exec_nop && !exec_valid)
    else $error("fetched word not squashed");
  AST_PREFETCH: assert property (fetch_valid && !pend && !skip_taken |=> exec_valid && exec_word == $past(fetch_word))
    else $error("fetched word not live");
  AST_FILE_ADDR: assert property (exec_valid |-> file_addr == exec_word[4:0])
    else $error("file address not from live word");
  AST_BUSY: assert property (test_busy == (exec_valid && exec_word[11:9] == 3'h3))
    else $error("test busy wrong");
  AST_NO_STATUS: assert property (status_we == 1'h0)
    else $error("status written");
  cover property (skip_taken && exec_word[8]);
  cover property (skip_taken && !exec_word[8]);
  cover property (exec_nop);
endmodule : bts_exec_props
bind bts_exec bts_exec_props u_props (.*);

// >>> bts_pkg.sv
// Shared constants for the bit-test-and-skip execute block
package bts_pkg;
  localparam int WORD_W = 12;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int BSEL_W = 3;
  localparam int OPC_W = 4;
  localparam int OPC_MSB = 11;
  localparam int OPC_LSB = 8;
  localparam int BSEL_MSB = 7;
  localparam int BSEL_LSB = 5;
  localparam int ADDR_MSB = 4;
  localparam int ADDR_LSB = 0;
  localparam logic [OPC_W-1:0] OPC_SKIP_CLEAR = 4'h6;
  localparam logic [OPC_W-1:0] OPC_SKIP_SET = 4'h7;
  localparam logic [WORD_W-1:0] NOP_WORD = 12'h000;
  localparam logic RST_VALID = 1'b0;
  localparam logic RST_SQUASH = 1'b0;
  localparam int RST_SYNC_STAGES = 2;
endpackage : bts_pkg

// >>> tb_top.sv
// Testbench for the bit-test-and-skip execute block
`timescale 1ns/1ns
module tb_top;
  logic core_clk = 0, reset_n = 0, fetch_valid = 0, exec_valid, exec_nop, skip_taken, test_busy, status_we;
  logic [11:0] fetch_word = 12'h000, exec_word;
  logic [7:0] file_rdata = 8'h00;
  logic [4:0] file_addr;
  int err_total = 0, compares = 0;
  bts_exec u_dut (.*);
  initial forever #4 core_clk = ~core_clk;
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  // Filler word 12'h123 is not a bit test, so it never skips
  task automatic bit_test(input logic [11:0] w, input logic [7:0] d, input logic exp);
    @(posedge core_clk) #1 fetch_valid = 1;
    fetch_word = w;
    @(posedge core_clk) #1 file_rdata = d;
    fetch_word = 12'h123;
    #1 chk("skip_taken", exp, skip_taken);
    chk("file_addr", w[4:0], file_addr);
    chk("test_busy", w[11:9] == 3'h3, test_busy);
    @(posedge core_clk) #1 fetch_valid = 0;
    #1 chk("exec_nop", exp, exec_nop);
    chk("exec_word", exp ? 12'h000 : 12'h123, exec_word);
    chk("exec_valid", !exp, exec_valid);
    chk("status_we", 12'h000, status_we);
  endtask : bit_test
  // Skip taken while fetch stalls; the late word is squashed and, though a set test, does not skip
  task automatic t_stall;
    @(posedge core_clk) #1 fetch_valid = 1;
    fetch_word = 12'h600;
    file_rdata = 8'h00;
    @(posedge core_clk) #1 fetch_valid = 0;
    #1 chk("skip_taken", 1'h1, skip_taken);
    @(posedge core_clk) #1 fetch_valid = 1;
    fetch_word = 12'h700;
    file_rdata = 8'hFF;
    #1 chk("exec_nop", 1'h0, exec_nop);
    @(posedge core_clk) #1 fetch_word = 12'h123;
    #1 chk("exec_nop", 1'h1, exec_nop);
    chk("skip_taken", 1'h0, skip_taken);
    chk("exec_word", 12'h000, exec_word);
    @(posedge core_clk) #1 fetch_valid = 0;
    #1 chk("exec_word", 12'h123, exec_word);
    chk("exec_valid", 1'h1, exec_valid);
  endtask : t_stall
  // Every bit, both opcodes, both values; other bits hold the opposite value
  task automatic t_tests;
    for (int i = 0; i < 32; i++)
      bit_test({i[4] ? 4'h7 : 4'h6, i[2:0], i[4:0]}, i[3] ? 8'h01 << i[2:0] : ~(8'h01 << i[2:0]), i[4] == i[3]);
  endtask : t_tests
  initial
  begin
    repeat (10) @(posedge core_clk);
    #1 reset_n = 1;
    repeat (3) @(posedge core_clk);
    t_tests;
    bit_test(12'h423, 8'h00, 1'h0);
    t_stall;
    conclude;
  end
  initial
  begin
    #40000 err_total++;
    conclude;
  end
endmodule : tb_top
